// >>> testbench/cufes_host.sv
// Host model driving the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module cufes_host (
	input wire logic i_clk,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [3:0] o_addr,
	output logic [7:0] o_data,
	input wire logic [7:0] i_data,
	input wire logic i_oe_n
);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = 4'h0;
		o_data = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_data = d;
		o_cs_n = 1'b0;
		o_wr_n = 1'b0;
		repeat (2) @(negedge i_clk);
		o_cs_n = 1'b1;
		o_wr_n = 1'b1;
		@(negedge i_clk);
		o_addr = ~a;
		o_data = ~d;
	endtask
	// Returns the drive enable above the read byte
	task automatic rd(input logic [3:0] a, output logic [8:0] r);
		@(negedge i_clk);
		o_addr = a;
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		repeat (2) @(negedge i_clk);
		r = {i_oe_n, i_data};
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		@(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> testbench/cufes_top_asserts.sv
// Concurrent checks on the ports of the card UART status block
`timescale 1ns/1ps
`default_nettype none
module cufes_top_asserts #(
	parameter int CLR_DELAY = 20
) (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic [cufes_pkg::AW-1:0] I_ADDR,
	input wire logic [cufes_pkg::DW-1:0] O_DATA,
	input wire logic O_DATA_OE_N,
	input wire logic O_INT_N,
	input wire logic I_TX_WRITE,
	input wire logic I_TO1,
	input wire logic I_TO2,
	input wire logic I_TO3,
	input wire logic I_EARLY_ANSWER,
	input wire logic O_RX_VALID,
	input wire logic [cufes_pkg::DW-1:0] O_RX_DATA,
	input wire logic I_RX_READ,
	input wire logic O_TX_RESEND,
	input wire logic O_CONTROL_READY
);
	import cufes_pkg::*;
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RESET);
	sequence s_status_rd;
		!I_CS_N && !I_RD_N && I_ADDR == ADDR_UART_STATUS;
	endsequence
	sequence s_deselected;
		I_CS_N [*3];
	endsequence
	a_reset_idle: assert property (disable iff (1'b0)
		I_RESET |=> O_INT_N && O_DATA_OE_N && !O_RX_VALID && !O_TX_RESEND)
		else $error("outputs not idle after reset");
	a_status_drive: assert property (
		s_status_rd |=> !O_DATA_OE_N)
		else $error("status read not driven");
	a_bus_release: assert property (
		s_deselected |-> O_DATA_OE_N)
		else $error("bus driven while deselected");
	a_idle_zero: assert property (
		O_DATA_OE_N |-> O_DATA == 8'h00)
		else $error("data not zero while released");
	a_rx_hold: assert property (
		O_RX_VALID && !I_RX_READ |=> O_RX_VALID && $stable(O_RX_DATA))
		else $error("received word dropped while stalled");
	a_timeout_irq: assert property (
		I_TO1 || I_TO2 || I_TO3 |-> ##[1:2] !O_INT_N)
		else $error("time-out did not interrupt");
	a_early_irq: assert property (
		I_EARLY_ANSWER |-> ##[1:2] !O_INT_N)
		else $error("early answer did not interrupt");
	a_resend_pulse: assert property (
		O_TX_RESEND |=> !O_TX_RESEND)
		else $error("resend start longer than one cycle");
	a_ready_back: assert property (
		I_TX_WRITE |-> ##[1:6] O_CONTROL_READY)
		else $error("control ready not restored");
endmodule
bind cufes_top cufes_top_asserts #(.CLR_DELAY(CLR_DELAY)) u_asserts (
	.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_CS_N(I_CS_N), .I_RD_N(I_RD_N),
	.I_ADDR(I_ADDR), .O_DATA(O_DATA), .O_DATA_OE_N(O_DATA_OE_N),
	.O_INT_N(O_INT_N), .I_TX_WRITE(I_TX_WRITE), .I_TO1(I_TO1),
	.I_TO2(I_TO2), .I_TO3(I_TO3), .I_EARLY_ANSWER(I_EARLY_ANSWER),
	.O_RX_VALID(O_RX_VALID), .O_RX_DATA(O_RX_DATA), .I_RX_READ(I_RX_READ),
	.O_TX_RESEND(O_TX_RESEND), .O_CONTROL_READY(O_CONTROL_READY));
`default_nettype wire

// >>> testbench/test_cufes_top.sv
// Testbench for the card UART FIFO, parity and status block
`timescale 1ns/1ps
`default_nettype none
module test_cufes_top;
	import cufes_pkg::*;
	localparam int CLRD = 20;
	logic clk = 0, rst = 1, t1 = 0, txm = 0, last_char_transmit_mode = 0, msk = 0, txw = 0;
	logic tick = 0, sb = 0, io = 1, rxv = 0, bad = 0, done = 0, nak = 0;
	logic rrd = 0, cs_n, rd_n, wr_n, oe_n, int_n, ov, ts, rs, cr;
	logic [3:0] evt = 4'h0, addr;
	logic [7:0] rxc = 8'h00, wdat, odat, orx;
	logic [8:0] r;
	logic [31:0] lf = 32'h644F;
	logic [7:0] q[$];
	int fails = 0, check_count = 0, n_rs = 0, n_ts = 0;
	cufes_top #(.CLR_DELAY(CLRD)) dut (
		.I_MCLK(clk), .I_RESET(rst), .I_CS_N(cs_n), .I_RD_N(rd_n),
		.I_WR_N(wr_n), .I_ADDR(addr), .I_DATA(wdat), .O_DATA(odat),
		.O_DATA_OE_N(oe_n), .O_INT_N(int_n), .I_PROTO_T1(t1),
		.I_TX_MODE(txm), .I_LCT(last_char_transmit_mode), .I_TXRX_IRQ_MASK(msk),
		.I_TX_WRITE(txw), .I_QETU_TICK(tick), .I_START_BIT(sb), .I_IO(io),
		.I_RX_CHAR_VALID(rxv), .I_RX_CHAR(rxc), .I_RX_PARITY_BAD(bad),
		.I_TX_DONE(done), .I_TX_NAK(nak), .I_TO1(evt[0]), .I_TO2(evt[1]),
		.I_TO3(evt[2]), .I_EARLY_ANSWER(evt[3]), .O_RX_VALID(ov),
		.O_RX_DATA(orx), .I_RX_READ(rrd), .O_TX_START(ts),
		.O_TX_RESEND(rs), .O_CONTROL_READY(cr));
	cufes_host hst (.i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_addr(addr), .o_data(wdat), .i_data(odat),
		.i_oe_n(oe_n));
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pl(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic st(input logic [7:0] e);
		hst.rd(ADDR_UART_STATUS, r);
		chk(r, {1'b0, e});
	endtask
	// Kinds: 0 good char, 1 bad char, 2 refusal, 3 refusal and rewrite, 4 none
	task automatic chr(input int kind, input logic [7:0] d);
		pl(sb);
		for (int i = 1; i <= 62; i++) begin
			pl(tick);
			if (i == 40) begin
				rxc = d;
				bad = kind == 1;
				rxv = kind < 2;
				nak = kind == 2 || kind == 3;
				if (kind == 0 || (kind == 1 && t1)) q.push_back(d);
				cyc(1);
				rxv = 1'b0;
				nak = 1'b0;
			end else if (i == 50 && kind == 3) begin
				pl(txw);
			end else begin
				cyc(1);
			end
		end
	endtask
	always @(posedge clk) begin
		if (ts) n_ts++;
		if (rs) n_rs++;
		if (ov && rrd) chk({1'b0, orx}, q.size() ? {1'b0, q.pop_front()} : 9'h1FF);
	end
	initial begin
		cyc(40000);
		fails++;
		test_done();
	end
	initial begin
		cyc(16);
		rst = 1'b0;
		cyc(1);
		st(8'h00);
		hst.rd(4'h3, r);
		chk(r, 9'h100);
		for (int i = 0; i < 4; i++) begin
			evt[i] = 1'b1;
			cyc(1);
			evt = 4'h0;
			cyc(2);
			chk({8'h00, int_n}, 9'h000);
			st(8'h01 << (i < 3 ? 5 + i : 4));
			cyc(CLRD + 10);
			st(8'h00);
			chk({8'h00, int_n}, 9'h001);
		end
		for (int f = 0; f < 8; f += 7) begin
			hst.wr(ADDR_FIFO_PARITY_CONFIG, 8'h88 | 8'(f));
			rrd = 1'b0;
			for (int i = 0; i < f + 4; i++) begin
				lf = nx(lf);
				rxc = lf[7:0];
				if (i < f + 3) q.push_back(rxc);
				pl(rxv);
				cyc(2);
			end
			st(8'h05);
			rrd = 1'b1;
			cyc(20);
			chk(9'(q.size()), 9'h000);
			cyc(CLRD);
			st(8'h00);
		end
		hst.wr(ADDR_FIFO_PARITY_CONFIG, 8'h20);
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			chr(i == 2 ? 0 : 1, lf[7:0]);
			if (i == 4) st(8'h00);
		end
		st(8'h08);
		cyc(5);
		st(8'h08);
		cyc(CLRD + 10);
		st(8'h00);
		io = 1'b0;
		chr(4, 8'h00);
		io = 1'b1;
		st(8'h02);
		t1 = 1'b1;
		chr(1, 8'hA5);
		st(8'h00);
		t1 = 1'b0;
		cyc(CLRD + 10);
		txm = 1'b1;
		cyc(3);
		st(8'h01);
		chk({8'h00, int_n}, 9'h000);
		msk = 1'b1;
		cyc(3);
		chk({8'h00, int_n}, 9'h001);
		msk = 1'b0;
		pl(txw);
		for (int k = 0; cr !== 1'b1; k++) begin
			if (k == 50) begin
				fails++;
				test_done();
			end
			cyc(1);
		end
		st(8'h00);
		hst.wr(ADDR_FIFO_PARITY_CONFIG, 8'h10);
		chr(2, 8'h00);
		chr(2, 8'h00);
		chk(9'(n_rs), 9'h001);
		st(8'h08);
		hst.wr(ADDR_FIFO_PARITY_CONFIG, 8'h00);
		cyc(CLRD + 10);
		chr(3, 8'h00);
		chk(9'(n_ts), 9'h001);
		chk(9'(n_rs), 9'h001);
		st(8'h08);
		cyc(CLRD + 10);
		last_char_transmit_mode = 1'b1;
		pl(done);
		st(8'h00);
		last_char_transmit_mode = 1'b0;
		pl(done);
		st(8'h01);
		txm = 1'b0;
		cyc(3);
		st(8'h00);
		cyc(20);
		test_done();
	end
endmodule
`default_nettype wire

// >>> verilog/cufes_buf2.sv
// Two-entry buffer between the reception FIFO and the host read port
`timescale 1ns/1ps
`default_nettype none
module cufes_buf2 #(parameter int W = 8) (
	input wire logic i_clk,
	input wire logic i_reset,
	cufes_stream_if.snk s_in,
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);
	logic [W-1:0] mem [2];
	logic wp;
	logic rp;
	logic [1:0] cnt;
	logic push;
	logic pop;

	assign s_in.ready = (cnt != 2'h2);
	assign push = s_in.valid && (cnt != 2'h2);
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) begin
				mem[wp] <= s_in.data;
				wp <= ~wp;
			end
			if (pop)
				rp <= ~rp;
			cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
		end
	end

	// Output word and valid held in flops
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_valid <= 1'b0;
			o_data <= '0;
		end else if (pop || !o_valid) begin
			if (pop && cnt == 2'h2) begin
				o_valid <= 1'b1;
				o_data <= mem[~rp];
			end else if (pop && push && cnt == 2'h1) begin
				o_valid <= 1'b1;
				o_data <= s_in.data;
			end else if (!pop && cnt == 2'h0 && push) begin
				o_valid <= 1'b1;
				o_data <= s_in.data;
			end else if (!pop && cnt != 2'h0) begin
				o_valid <= 1'b1;
				o_data <= mem[rp];
			end else begin
				o_valid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verilog/cufes_pkg.sv
// Constants for the card UART FIFO, parity and status block
// Overview of operation
// - Write-only 8-bit FIFO and parity configuration register at 0Ch, cleared by reset.
// - Parity error count field bits 6:4 sets the threshold at value plus one.
// - In T=0 a good character before the threshold clears the error counter.
// - Reaching the threshold sets the parity flag until 2 ms after the status register is read.
// - In T=0 a NAKed character is resent automatically up to count times at 15 ETU.
// - With count zero resending is off; a rewritten character starts at 13.5 ETU.
// - FIFO length field bits 2:0 sets reception FIFO depth at value plus one.
// - Interrupt output goes low while any error, early answer or time-out flag is set.
// - The flag that raised the interrupt clears 2 ms after the status read strobe rises.
// - Transmit-empty or receive-full also pulls interrupt low unless masked.
// - That flag clears 3 cycles after data write or read, or on transmit to receive.
// - In last-character mode transmit-empty is not set after the transmission.
// - Read-only status register at 0Eh, bits time-outs, early answer, errors, buffer flag.
// - Overrun flag is set when a character arrives while the FIFO is full.
// - Framing flag is set when the data line is low at 10.25 ETU after start.
// - Parity flag at 10.5 ETU receiving, 11.5 ETU sending; bad T=0 characters dropped.
// - In T=1 bad-parity characters are stored and the error counter stays idle.
package cufes_pkg;
	localparam int AW = 4;
	localparam int DW = 8;
	localparam logic [3:0] ADDR_FIFO_PARITY_CONFIG = 4'hC;
	localparam logic [3:0] ADDR_UART_STATUS = 4'hE;
	localparam int PEC_LSB = 4;
	localparam int FL_LSB = 0;
	localparam logic [2:0] PEC_RESET = 3'h0;
	localparam logic [2:0] FL_RESET = 3'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int ST_TO3 = 7;
	localparam int ST_TO2 = 6;
	localparam int ST_TO1 = 5;
	localparam int ST_EA = 4;
	localparam int ST_PE = 3;
	localparam int ST_OVR = 2;
	localparam int ST_FER = 1;
	localparam int ST_TBRB = 0;
	// Card timing in hundredths of an ETU, counted in quarter ETU ticks
	localparam int FER_ETU_X100 = 1025;
	localparam int PE_RX_ETU_X100 = 1050;
	localparam int PE_TX_ETU_X100 = 1150;
	localparam int MANUAL_ETU_X100 = 1350;
	localparam int RESEND_ETU_X100 = 1500;
	localparam logic [6:0] FER_Q = 7'(FER_ETU_X100 * 4 / 100);
	localparam logic [6:0] PE_RX_Q = 7'(PE_RX_ETU_X100 * 4 / 100);
	localparam logic [6:0] PE_TX_Q = 7'(PE_TX_ETU_X100 * 4 / 100);
	localparam logic [6:0] MANUAL_Q = 7'(MANUAL_ETU_X100 * 4 / 100);
	localparam logic [6:0] RESEND_Q = 7'(RESEND_ETU_X100 * 4 / 100);
	localparam int CLK_MHZ = 100;
	localparam int CLR_DELAY_US = 2000;
	localparam int CLR_DELAY_CYC = CLR_DELAY_US * CLK_MHZ;
	localparam int TBRB_CLR_CYC = 3;
	localparam int FIFO_MAX = 8;
endpackage

// >>> verilog/cufes_stream_if.sv
// Valid and ready stream carrying received characters
`timescale 1ns/1ps
`default_nettype none
interface cufes_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> verilog/cufes_top.sv
// Card UART FIFO and parity configuration, error counting and status register
`timescale 1ns/1ps
`default_nettype none
module cufes_top #(
	parameter int CLR_DELAY = cufes_pkg::CLR_DELAY_CYC
) (
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic [cufes_pkg::AW-1:0] I_ADDR,
	input wire logic [cufes_pkg::DW-1:0] I_DATA,
	output logic [cufes_pkg::DW-1:0] O_DATA,
	output logic O_DATA_OE_N,
	output logic O_INT_N,
	input wire logic I_PROTO_T1,
	input wire logic I_TX_MODE,
	input wire logic I_LCT,
	input wire logic I_TXRX_IRQ_MASK,
	input wire logic I_TX_WRITE,
	input wire logic I_QETU_TICK,
	input wire logic I_START_BIT,
	input wire logic I_IO,
	input wire logic I_RX_CHAR_VALID,
	input wire logic [cufes_pkg::DW-1:0] I_RX_CHAR,
	input wire logic I_RX_PARITY_BAD,
	input wire logic I_TX_DONE,
	input wire logic I_TX_NAK,
	input wire logic I_TO1,
	input wire logic I_TO2,
	input wire logic I_TO3,
	input wire logic I_EARLY_ANSWER,
	output logic O_RX_VALID,
	output logic [cufes_pkg::DW-1:0] O_RX_DATA,
	input wire logic I_RX_READ,
	output logic O_TX_START,
	output logic O_TX_RESEND,
	output logic O_CONTROL_READY
);
	import cufes_pkg::*;

	localparam logic [17:0] CLR_LOAD = 18'(CLR_DELAY);

	logic cs_q;
	logic rd_n_q;
	logic wr_n_q;
	logic [3:0] addr_q;
	logic [7:0] data_q;
	logic [2:0] parity_count;
	logic [2:0] fifo_depth;
	logic [7:0] status;
	logic [7:0] next_status;
	logic stat_read;
	logic [6:0] clr_snap;
	logic [17:0] clr_timer;
	logic clr_fire;
	logic [6:0] qcnt;
	logic [2:0] perr_cnt;
	logic pe_rx_pend;
	logic pe_tx_pend;
	logic resend_pend;
	logic manual_pend;
	logic nak_manual;
	logic [2:0] resend_cnt;
	logic [DW-1:0] fifo_mem [FIFO_MAX];
	logic [2:0] fifo_wp;
	logic [2:0] fifo_rp;
	logic [3:0] fifo_cnt;
	logic fifo_full;
	logic fifo_push;
	logic fifo_pop;
	logic overrun_ev;
	logic rx_good;
	logic rx_bad_t0;
	logic tx_mode_q;
	logic [TBRB_CLR_CYC-1:0] tbrb_clr_pipe;
	logic tbrb_set;
	logic tbrb_clr;
	logic rx_pop_ev;

	cufes_stream_if #(.W(DW)) fifo_out ();

	// Quarter ETU milestone after the latest start bit
	function automatic logic at_q(input logic [6:0] cnt, input logic [6:0] q);
		return cnt == 7'(q - 7'h01);
	endfunction

	// Bus strobes sampled each clock
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			cs_q <= 1'b0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			addr_q <= 4'h0;
			data_q <= 8'h00;
		end else begin
			cs_q <= ~I_CS_N;
			rd_n_q <= I_RD_N;
			wr_n_q <= I_WR_N;
			addr_q <= I_ADDR;
			data_q <= I_DATA;
		end
	end

	// Configuration write on the rising edge of the write strobe
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			parity_count <= PEC_RESET;
			fifo_depth <= FL_RESET;
		end else if (cs_q && !wr_n_q && I_WR_N
			&& addr_q == ADDR_FIFO_PARITY_CONFIG) begin
			parity_count <= data_q[PEC_LSB +: 3];
			fifo_depth <= data_q[FL_LSB +: 3];
		end
	end

	assign stat_read = ~I_CS_N && ~I_RD_N && I_ADDR == ADDR_UART_STATUS;

	// Read data and bus drive enable
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			O_DATA <= 8'h00;
			O_DATA_OE_N <= 1'b1;
		end else begin
			O_DATA <= stat_read ? status : 8'h00;
			O_DATA_OE_N <= ~stat_read;
		end
	end

	// Snapshot of flags raised at read, cleared after the delay
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			clr_snap <= 7'h00;
			clr_timer <= 18'h0;
		end else if (cs_q && !rd_n_q && I_RD_N && addr_q == ADDR_UART_STATUS) begin
			clr_snap <= clr_snap | status[7:1];
			clr_timer <= CLR_LOAD;
		end else if (clr_timer != 18'h0) begin
			clr_timer <= 18'(clr_timer - 18'h1);
		end else begin
			clr_snap <= 7'h00;
		end
	end

	assign clr_fire = (clr_timer == 18'h1);

	// Quarter ETU counter since the start bit
	always_ff @(posedge I_MCLK) begin
		if (I_RESET)
			qcnt <= 7'h7F;
		else if (I_START_BIT)
			qcnt <= 7'h00;
		else if (I_QETU_TICK && qcnt != 7'h7F)
			qcnt <= 7'(qcnt + 7'h01);
	end

	assign rx_good = I_RX_CHAR_VALID && !I_RX_PARITY_BAD;
	assign rx_bad_t0 = I_RX_CHAR_VALID && I_RX_PARITY_BAD && !I_PROTO_T1;

	// Parity error counter and retransmission control
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			perr_cnt <= 3'h0;
			pe_rx_pend <= 1'b0;
			pe_tx_pend <= 1'b0;
			resend_pend <= 1'b0;
			resend_cnt <= 3'h0;
			nak_manual <= 1'b0;
		end else begin
			if (I_TX_MODE && I_TX_NAK && !I_PROTO_T1) begin
				if (perr_cnt == parity_count) begin
					pe_tx_pend <= 1'b1;
					perr_cnt <= 3'h0;
				end else begin
					perr_cnt <= 3'(perr_cnt + 3'h1);
				end
				if (parity_count == 3'h0) begin
					nak_manual <= 1'b1;
				end else if (resend_cnt != parity_count) begin
					resend_pend <= 1'b1;
					resend_cnt <= 3'(resend_cnt + 3'h1);
				end
			end else if (!I_TX_MODE && rx_bad_t0) begin
				if (perr_cnt == parity_count) begin
					pe_rx_pend <= 1'b1;
					perr_cnt <= 3'h0;
				end else begin
					perr_cnt <= 3'(perr_cnt + 3'h1);
				end
			end else if ((rx_good && !I_TX_MODE && !I_PROTO_T1)
				|| (I_TX_DONE && I_TX_MODE)) begin
				perr_cnt <= 3'h0;
				resend_cnt <= 3'h0;
			end
			if (I_QETU_TICK && at_q(qcnt, PE_RX_Q))
				pe_rx_pend <= 1'b0;
			if (I_QETU_TICK && at_q(qcnt, PE_TX_Q))
				pe_tx_pend <= 1'b0;
			if (I_QETU_TICK && at_q(qcnt, RESEND_Q))
				resend_pend <= 1'b0;
			if (I_TX_WRITE)
				nak_manual <= 1'b0;
		end
	end

	// Manual rewrite after a NAK with resending off
	always_ff @(posedge I_MCLK) begin
		if (I_RESET)
			manual_pend <= 1'b0;
		else if (I_TX_WRITE && nak_manual)
			manual_pend <= 1'b1;
		else if (I_QETU_TICK && at_q(qcnt, MANUAL_Q))
			manual_pend <= 1'b0;
	end

	// Transmit start pulses
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			O_TX_START <= 1'b0;
			O_TX_RESEND <= 1'b0;
		end else begin
			O_TX_START <= manual_pend && I_QETU_TICK
				&& at_q(qcnt, MANUAL_Q);
			O_TX_RESEND <= resend_pend && I_QETU_TICK
				&& at_q(qcnt, RESEND_Q);
		end
	end

	// Reception FIFO
	assign fifo_full = fifo_cnt > {1'b0, fifo_depth};
	assign fifo_pop = fifo_cnt != 4'h0 && fifo_out.ready;
	assign fifo_push = I_RX_CHAR_VALID && !I_TX_MODE && !rx_bad_t0
		&& (!fifo_full || fifo_pop);
	assign overrun_ev = I_RX_CHAR_VALID && !I_TX_MODE && !rx_bad_t0
		&& fifo_full && !fifo_pop;
	assign fifo_out.valid = fifo_cnt != 4'h0;
	assign fifo_out.data = fifo_mem[fifo_rp];

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			fifo_wp <= 3'h0;
			fifo_rp <= 3'h0;
			fifo_cnt <= 4'h0;
		end else begin
			if (fifo_push) begin
				fifo_mem[fifo_wp] <= I_RX_CHAR;
				fifo_wp <= (fifo_wp == fifo_depth) ? 3'h0 : 3'(fifo_wp + 3'h1);
			end
			if (fifo_pop)
				fifo_rp <= (fifo_rp == fifo_depth) ? 3'h0 : 3'(fifo_rp + 3'h1);
			fifo_cnt <= 4'(fifo_cnt + {3'h0, fifo_push} - {3'h0, fifo_pop});
		end
	end

	cufes_buf2 #(.W(DW)) u_buf (
		.i_clk(I_MCLK),
		.i_reset(I_RESET),
		.s_in(fifo_out),
		.o_valid(O_RX_VALID),
		.o_data(O_RX_DATA),
		.i_ready(I_RX_READ)
	);

	assign rx_pop_ev = O_RX_VALID && I_RX_READ;

	// Delayed clear of the buffer flag after data access
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			tbrb_clr_pipe <= '0;
			tx_mode_q <= 1'b0;
		end else begin
			tbrb_clr_pipe <= {tbrb_clr_pipe[TBRB_CLR_CYC-2:0],
				I_TX_WRITE || rx_pop_ev};
			tx_mode_q <= I_TX_MODE;
		end
	end

	// Control ready low while a data access is still settling
	always_ff @(posedge I_MCLK) begin
		if (I_RESET)
			O_CONTROL_READY <= 1'b1;
		else
			O_CONTROL_READY <= !(I_TX_WRITE || rx_pop_ev)
				&& tbrb_clr_pipe[TBRB_CLR_CYC-2:0] == '0;
	end

	assign tbrb_set = (I_TX_MODE && !tx_mode_q)
		|| (!I_TX_MODE && fifo_full)
		|| (I_TX_MODE && I_TX_DONE && !I_LCT);
	assign tbrb_clr = tbrb_clr_pipe[TBRB_CLR_CYC-1]
		|| (!I_TX_MODE && tx_mode_q);

	// Status flags: a new event wins over a clear
	always_comb begin
		next_status = status;
		if (clr_fire)
			next_status[7:1] = status[7:1] & ~clr_snap;
		if (tbrb_clr)
			next_status[ST_TBRB] = 1'b0;
		if (I_TO3)
			next_status[ST_TO3] = 1'b1;
		if (I_TO2)
			next_status[ST_TO2] = 1'b1;
		if (I_TO1)
			next_status[ST_TO1] = 1'b1;
		if (I_EARLY_ANSWER)
			next_status[ST_EA] = 1'b1;
		if ((pe_rx_pend && I_QETU_TICK && at_q(qcnt, PE_RX_Q))
			|| (pe_tx_pend && I_QETU_TICK && at_q(qcnt, PE_TX_Q)))
			next_status[ST_PE] = 1'b1;
		if (overrun_ev)
			next_status[ST_OVR] = 1'b1;
		if (!I_TX_MODE && I_QETU_TICK && at_q(qcnt, FER_Q) && !I_IO)
			next_status[ST_FER] = 1'b1;
		if (tbrb_set)
			next_status[ST_TBRB] = 1'b1;
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET)
			status <= STATUS_RESET;
		else
			status <= next_status;
	end

	// Interrupt, active low
	always_ff @(posedge I_MCLK) begin
		if (I_RESET)
			O_INT_N <= 1'b1;
		else
			O_INT_N <= ~((|next_status[7:1])
				|| (next_status[ST_TBRB] && !I_TXRX_IRQ_MASK));
	end
endmodule
`default_nettype wire
